// File: logic/shs_defines.svh
`ifndef SHS_DEFINES_SVH
`define SHS_DEFINES_SVH

// bus address and register offsets
`define SHS_SLAVE_ADDR 7'h43
`define SHS_ADR_SYSTEM_CONTROL 8'h10
`define SHS_ADR_RUN_MODE_SELECT 8'h21
`define SHS_ADR_SENS_START 8'h22
`define SHS_ADR_SENS_STOP 8'h23
`define SHS_ADR_SENSOR_ACTIVITY_STATUS 8'h24
`define SHS_ADR_T_VAL 8'h30
`define SHS_ADR_H_VAL 8'h33
// field positions
`define SHS_BIT_T 0
`define SHS_BIT_H 1
`define SHS_BIT_LOWPOWER 0
`define SHS_BIT_ACTIVE 7
// reset values
`define SHS_RST_SYSTEM_CONTROL 8'h01
// timing, in microseconds, and the 200 MHz clock in MHz
`define SHS_CLK_MHZ 200
`define SHS_T_BOOT_US 1000
`define SHS_T_BOOT_MAX_US 1200
`define SHS_T_ONLY_US 104000
`define SHS_TH_US 122000
`define SHS_BOOT_CYC (`SHS_T_BOOT_US * `SHS_CLK_MHZ)
`define SHS_T_CYC (`SHS_T_ONLY_US * `SHS_CLK_MHZ)
`define SHS_TH_CYC (`SHS_TH_US * `SHS_CLK_MHZ)

`endif

// File: logic/shs_pkg.sv
package shs_pkg;
    typedef enum logic [1:0] {PWR_STANDBY, PWR_BOOTING, PWR_ACTIVE} shs_pwr_e;
    typedef logic [7:0] shs_byte_t;
endpackage : shs_pkg

// File: logic/shs_sync.sv
`timescale 1ns/100ps
module shs_sync (
    input wire logic i_clk, // clock
    input wire logic i_rst_n, // sync reset
    input wire logic i_d, // async level
    output logic o_q // synchronised level
);
    logic s1_reg;
    logic s2_reg;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
        end else begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
        end
    end
    assign o_q = s2_reg;
endmodule : shs_sync

// File: logic/shs_top.sv
`timescale 1ns/100ps
`include "shs_defines.svh"
module shs_top #(
    parameter int BOOT_CYC = `SHS_BOOT_CYC, // booting duration
    parameter int T_CYC = `SHS_T_CYC, // temperature conversion
    parameter int TH_CYC = `SHS_TH_CYC // temperature plus humidity
) (
    input wire logic I_CLK, // 200 MHz clock
    input wire logic I_RST_N, // sync reset, low
    input wire logic I_SCL, // bus clock pin
    input wire logic I_SDA, // bus data pin in
    output logic O_SDA, // bus data out, always 0
    output logic O_SDA_OE, // high pulls data low
    input wire logic [15:0] I_T_DATA, // temperature result
    input wire logic [15:0] I_H_DATA, // humidity result
    output logic O_ENGINE_ON, // measurement engine powered
    output shs_pkg::shs_pwr_e O_PWR_STATE // power state
);
    import shs_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    // oversampled pins, any rate up to 400 kbit/s
    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;
    shs_sync u_sync_scl (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_d(I_SCL), .o_q(scl_s));
    shs_sync u_sync_sda (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_d(I_SDA), .o_q(sda_s));
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end
    wire scl_rise = scl_s && !scl_d_reg;
    wire scl_fall = !scl_s && scl_d_reg;
    wire start_det = scl_s && scl_d_reg && !sda_s && sda_d_reg;
    wire stop_det = scl_s && scl_d_reg && sda_s && !sda_d_reg;

    // ****************************************
    // bus slave state
    // ****************************************
    typedef enum logic [2:0] {BS_IDLE, BS_ADDR, BS_ACK, BS_WRX, BS_RDX, BS_RACK} shs_bus_e;
    shs_bus_e bus_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic rd_dir_reg;
    logic ptr_phase_reg;
    logic ack_drv_reg;
    logic sda_drv_reg;
    shs_byte_t ptr_reg;
    logic wr_stb;
    logic rd_stb;
    logic wr_ok;
    shs_byte_t rd_data;

    // control and status registers
    logic [7:0] system_control_reg;
    logic [1:0] run_reg;
    logic [1:0] start_reg;
    logic [1:0] stop_reg;
    logic [1:0] stat_reg;
    logic [1:0] valid_reg;
    logic [15:0] t_meas_reg;
    logic [15:0] h_meas_reg;
    logic [7:0] t_snap_reg [0:1];
    logic [7:0] h_snap_reg [0:1];
    shs_pwr_e pwr_reg;
    logic busy;
    assign busy = (stat_reg != 2'b00);

    always_comb begin
        if (ptr_reg == `SHS_ADR_SYSTEM_CONTROL) begin
            wr_ok = 1'b1;
        end else if (ptr_reg >= `SHS_ADR_RUN_MODE_SELECT && ptr_reg <= `SHS_ADR_SENS_STOP) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    // ****************************************
    // bus protocol engine
    // ****************************************
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            bus_reg <= BS_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            rd_dir_reg <= 1'b0;
            ptr_phase_reg <= 1'b0;
            ack_drv_reg <= 1'b0;
            sda_drv_reg <= 1'b0;
            ptr_reg <= 8'h00;
        end else if (stop_det) begin
            bus_reg <= BS_IDLE;
            sda_drv_reg <= 1'b0;
        end else if (start_det) begin
            bus_reg <= BS_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_drv_reg <= 1'b0;
        end else begin
            case (bus_reg)
                BS_ADDR, BS_WRX: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                    end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                        bit_cnt_reg <= 4'h0;
                        if (bus_reg == BS_ADDR) begin
                            if (shift_reg[7:1] == `SHS_SLAVE_ADDR) begin
                                rd_dir_reg <= shift_reg[0];
                                ptr_phase_reg <= !shift_reg[0];
                                ack_drv_reg <= 1'b1;
                                sda_drv_reg <= 1'b1;
                                bus_reg <= BS_ACK;
                            end else begin
                                bus_reg <= BS_IDLE;
                            end
                        end else if (ptr_phase_reg) begin
                            ptr_reg <= shift_reg;
                            ptr_phase_reg <= 1'b0;
                            sda_drv_reg <= 1'b1;
                            bus_reg <= BS_ACK;
                        end else begin
                            sda_drv_reg <= wr_ok;
                            ptr_reg <= 8'(ptr_reg + 8'h01);
                            bus_reg <= BS_ACK;
                        end
                    end
                end
                BS_ACK: begin
                    if (scl_fall) begin
                        if (rd_dir_reg && ack_drv_reg) begin
                            shift_reg <= rd_data;
                            sda_drv_reg <= !rd_data[7];
                            ptr_reg <= 8'(ptr_reg + 8'h01);
                            bit_cnt_reg <= 4'h1;
                            bus_reg <= BS_RDX;
                        end else begin
                            sda_drv_reg <= 1'b0;
                            bus_reg <= BS_WRX;
                        end
                        ack_drv_reg <= 1'b0;
                    end
                end
                BS_RDX: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == 4'h8) begin
                            sda_drv_reg <= 1'b0;
                            bus_reg <= BS_RACK;
                        end else begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            sda_drv_reg <= !shift_reg[6];
                            bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                        end
                    end
                end
                BS_RACK: begin
                    if (scl_rise && sda_s) begin
                        bus_reg <= BS_IDLE;
                    end else if (scl_rise) begin
                        ack_drv_reg <= 1'b1;
                        bus_reg <= BS_ACK;
                    end
                end
                default: begin
                    sda_drv_reg <= 1'b0;
                end
            endcase
        end
    end
    assign O_SDA = 1'b0;
    assign O_SDA_OE = sda_drv_reg;
    assign wr_stb = (bus_reg == BS_WRX) && scl_fall && bit_cnt_reg == 4'h8 && !ptr_phase_reg
        && wr_ok && !stop_det && !start_det;
    assign rd_stb = (bus_reg == BS_ACK) && scl_fall && rd_dir_reg && ack_drv_reg
        && !stop_det && !start_det;

    // ****************************************
    // read multiplexer
    // ****************************************
    always_comb begin
        if (ptr_reg == `SHS_ADR_SYSTEM_CONTROL) begin
            rd_data = system_control_reg;
        end else if (ptr_reg == `SHS_ADR_RUN_MODE_SELECT) begin
            rd_data = {6'h00, run_reg};
        end else if (ptr_reg == `SHS_ADR_SENS_START) begin
            rd_data = {6'h00, start_reg};
        end else if (ptr_reg == `SHS_ADR_SENS_STOP) begin
            rd_data = {6'h00, stop_reg};
        end else if (ptr_reg == `SHS_ADR_SENSOR_ACTIVITY_STATUS) begin
            rd_data = {pwr_reg == PWR_ACTIVE, 5'h00, stat_reg};
        end else if (ptr_reg == `SHS_ADR_T_VAL) begin
            rd_data = t_meas_reg[7:0];
        end else if (ptr_reg == 8'(`SHS_ADR_T_VAL + 1)) begin
            rd_data = t_snap_reg[0];
        end else if (ptr_reg == 8'(`SHS_ADR_T_VAL + 2)) begin
            rd_data = t_snap_reg[1];
        end else if (ptr_reg == `SHS_ADR_H_VAL) begin
            rd_data = h_meas_reg[7:0];
        end else if (ptr_reg == 8'(`SHS_ADR_H_VAL + 1)) begin
            rd_data = h_snap_reg[0];
        end else if (ptr_reg == 8'(`SHS_ADR_H_VAL + 2)) begin
            rd_data = h_snap_reg[1];
        end else begin
            rd_data = 8'h00;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            t_snap_reg[0] <= 8'h00;
            t_snap_reg[1] <= 8'h00;
            h_snap_reg[0] <= 8'h00;
            h_snap_reg[1] <= 8'h00;
        end else if (rd_stb && ptr_reg == `SHS_ADR_T_VAL) begin
            t_snap_reg[0] <= t_meas_reg[15:8];
            t_snap_reg[1] <= {7'h00, valid_reg[`SHS_BIT_T]};
        end else if (rd_stb && ptr_reg == `SHS_ADR_H_VAL) begin
            h_snap_reg[0] <= h_meas_reg[15:8];
            h_snap_reg[1] <= {7'h00, valid_reg[`SHS_BIT_H]};
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // writes accepted in any power state
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            system_control_reg <= `SHS_RST_SYSTEM_CONTROL;
        end else if (wr_stb && ptr_reg == `SHS_ADR_SYSTEM_CONTROL) begin
            system_control_reg <= shift_reg;
        end
    end
    // pending requests latch now, act between measurements
    logic [1:0] run_pend_reg;
    logic step_go;
    logic step_end;
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            run_pend_reg <= 2'b00;
            run_reg <= 2'b00;
            start_reg <= 2'b00;
            stop_reg <= 2'b00;
        end else begin
            if (wr_stb && ptr_reg == `SHS_ADR_RUN_MODE_SELECT) begin
                run_pend_reg <= shift_reg[1:0];
            end
            if (!busy) begin
                run_reg <= run_pend_reg;
            end
            if (step_end && !(run_reg != 2'b00 && stop_reg == 2'b00)) begin
                start_reg <= 2'b00;
                stop_reg <= 2'b00;
            end
            // write after the clear so a late request is not lost
            if (wr_stb && ptr_reg == `SHS_ADR_SENS_START) begin
                start_reg <= start_reg | shift_reg[1:0];
            end
            if (wr_stb && ptr_reg == `SHS_ADR_SENS_STOP) begin
                stop_reg <= stop_reg | shift_reg[1:0];
            end
        end
    end

    // ****************************************
    // power and measurement sequencing
    // ****************************************
    logic [31:0] cnt_reg;
    logic [31:0] conv_cyc;
    logic meas_req;
    assign meas_req = (start_reg != 2'b00);
    assign conv_cyc = (start_reg == 2'b11) ? 32'(TH_CYC) : 32'(T_CYC);
    assign step_go = (pwr_reg == PWR_ACTIVE) && !busy && meas_req;
    assign step_end = busy && cnt_reg == 32'h0000_0001;
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            pwr_reg <= PWR_BOOTING;
            cnt_reg <= 32'(BOOT_CYC);
            stat_reg <= 2'b00;
            valid_reg <= 2'b00;
            t_meas_reg <= 16'h0000;
            h_meas_reg <= 16'h0000;
        end else begin
            case (pwr_reg)
                PWR_STANDBY: begin
                    if (meas_req || !system_control_reg[`SHS_BIT_LOWPOWER]) begin
                        pwr_reg <= PWR_BOOTING;
                        cnt_reg <= 32'(BOOT_CYC);
                    end
                end
                PWR_BOOTING: begin
                    if (cnt_reg <= 32'h0000_0001) begin
                        pwr_reg <= PWR_ACTIVE;
                    end else begin
                        cnt_reg <= cnt_reg - 32'h0000_0001;
                    end
                end
                default: begin
                    if (step_go) begin
                        stat_reg <= start_reg;
                        valid_reg <= valid_reg & ~(start_reg & ~run_reg);
                        cnt_reg <= conv_cyc;
                    end else if (step_end) begin
                        if (stat_reg[`SHS_BIT_T]) t_meas_reg <= I_T_DATA;
                        if (stat_reg[`SHS_BIT_H]) h_meas_reg <= I_H_DATA;
                        valid_reg <= valid_reg | stat_reg;
                        stat_reg <= 2'b00;
                    end else if (busy) begin
                        cnt_reg <= cnt_reg - 32'h0000_0001;
                    end else if (!meas_req && system_control_reg[`SHS_BIT_LOWPOWER]) begin
                        // stay active unless low power and idle
                        pwr_reg <= PWR_STANDBY;
                    end
                end
            endcase
        end
    end
    assign O_ENGINE_ON = (pwr_reg != PWR_STANDBY);
    assign O_PWR_STATE = pwr_reg;

    // ****************************************
    // assertions
    // ****************************************
    AST_BOOT_TIMED: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        $rose(pwr_reg == PWR_BOOTING) |-> (pwr_reg == PWR_BOOTING)[*2])
        else $error("booting left too early");
    AST_NO_STRETCH: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_SDA == 1'b0)
        else $error("data output not low");
    AST_STANDBY_IDLE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        pwr_reg == PWR_STANDBY |-> !busy)
        else $error("measurement in standby");
    AST_LOWPWR_OFF: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (pwr_reg == PWR_ACTIVE && !system_control_reg[`SHS_BIT_LOWPOWER]) |=> pwr_reg == PWR_ACTIVE)
        else $error("left active with low power off");
    AST_PTR_INC: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        wr_stb |=> ptr_reg == 8'($past(ptr_reg) + 8'h01))
        else $error("pointer not incremented");
    AST_NACK_RO: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (bus_reg == BS_WRX && scl_fall && bit_cnt_reg == 4'h8 && !ptr_phase_reg && !wr_ok
         && !start_det && !stop_det) |=> !sda_drv_reg)
        else $error("read-only write acknowledged");
    AST_ADDR_NACK: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (bus_reg == BS_ADDR && scl_fall && bit_cnt_reg == 4'h8 && !start_det && !stop_det
         && shift_reg[7:1] != `SHS_SLAVE_ADDR) |=> !sda_drv_reg)
        else $error("foreign address acknowledged");
    AST_STEP_END: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        step_end |=> !busy ##0 valid_reg == ($past(valid_reg) | $past(stat_reg)))
        else $error("step end did not set valid");
    AST_SNAP: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (rd_stb && ptr_reg == `SHS_ADR_T_VAL) |=> t_snap_reg[0] == $past(t_meas_reg[15:8]))
        else $error("snapshot missed");
    COV_BOOT: cover property (@(posedge I_CLK) pwr_reg == PWR_BOOTING ##1 pwr_reg == PWR_ACTIVE);
    COV_WRITE: cover property (@(posedge I_CLK) wr_stb);
    COV_READ: cover property (@(posedge I_CLK) rd_stb);
    COV_MEAS: cover property (@(posedge I_CLK) step_end);
endmodule : shs_top

// File: sim/sensor_i2c_slave_power_fsm_bench.sv
`timescale 1ns/100ps
`define SHS_CHECK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module sensor_i2c_slave_power_fsm_bench;
    import shs_pkg::*;
    // short counts keep the run brief; the bus rate dominates anyway
    localparam int BOOT = 20;
    localparam int TC = 100;
    localparam int TH = 150;
    logic clk;
    logic rst_n;
    logic m_scl;
    logic m_low;
    logic sda_oe;
    logic sda_o;
    logic engine_on;
    logic [15:0] t_data;
    logic [15:0] h_data;
    shs_pwr_e pwr;
    shs_pwr_e last_pwr;
    shs_pwr_e seen[$];
    int act_cnt;
    int fails;
    int n_checks;
    wire sda = !(m_low | sda_oe);
    // ************************************
    // structure
    // ************************************
    shs_top #(
        .BOOT_CYC(BOOT),
        .T_CYC(TC),
        .TH_CYC(TH)
    ) uut (
        .I_CLK(clk),
        .I_RST_N(rst_n),
        .I_SCL(m_scl),
        .I_SDA(sda),
        .O_SDA(sda_o),
        .O_SDA_OE(sda_oe),
        .I_T_DATA(t_data),
        .I_H_DATA(h_data),
        .O_ENGINE_ON(engine_on),
        .O_PWR_STATE(pwr)
    );
    shs_i2c_master mst (
        .i_clk(clk),
        .i_sda(sda),
        .o_scl(m_scl),
        .o_sda_low(m_low)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (pwr !== last_pwr) begin
            seen.push_back(pwr);
        end
        last_pwr = pwr;
        if (pwr === PWR_ACTIVE) begin
            act_cnt++;
        end
        if (rst_n === 1'b1) begin
            `SHS_CHECK(engine_on, pwr !== PWR_STANDBY)
        end
    end
    // ************************************
    // tasks
    // ************************************
    task automatic put(input shs_byte_t d, input logic ack);
        logic a;
        mst.wr_byte(d, a);
        `SHS_CHECK(a, ack)
    endtask : put
    task automatic get(input logic last, input shs_byte_t exp);
        shs_byte_t d;
        mst.rd_byte(last, d);
        `SHS_CHECK(d, exp)
    endtask : get
    task automatic wait_pwr(input shs_pwr_e s, input int lim, output int n);
        n = 0;
        while (pwr !== s && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_pwr
    task automatic test_reset();
        int n;
        @(negedge clk);
        `SHS_CHECK(pwr, PWR_BOOTING)
        `SHS_CHECK(sda_oe, 1'b0)
        `SHS_CHECK(sda_o, 1'b0)
        @(posedge clk);
        rst_n <= 1'b1;
        wait_pwr(PWR_ACTIVE, 200, n);
        `SHS_CHECK(n inside {[BOOT - 1:BOOT + 3]}, 1'b1)
        `SHS_CHECK(pwr, PWR_ACTIVE)
        wait_pwr(PWR_STANDBY, 20, n);
        `SHS_CHECK(pwr, PWR_STANDBY)
        $display("test reset done");
    endtask : test_reset
    task automatic test_foreign();
        mst.start();
        put(8'h88, 1'b0);
        mst.stop();
        $display("test foreign address done");
    endtask : test_foreign
    task automatic test_single();
        int n;
        shs_pwr_e exp_seq[3];
        exp_seq = '{PWR_BOOTING, PWR_ACTIVE, PWR_STANDBY};
        seen.delete();
        act_cnt = 0;
        mst.start();
        put(8'h86, 1'b1);
        put(8'h21, 1'b1);
        put(8'h00, 1'b1);
        put(8'h01, 1'b1);
        mst.stop();
        wait_pwr(PWR_STANDBY, 2000, n);
        `SHS_CHECK(seen.size(), 3)
        for (int i = 0; i < 3; i++) begin
            `SHS_CHECK(seen[i], exp_seq[i])
        end
        `SHS_CHECK(act_cnt inside {[TC - 1:TC + 3]}, 1'b1)
        $display("test single shot done");
    endtask : test_single
    task automatic test_readout();
        logic [15:0] old_t;
        old_t = t_data;
        // result was taken at step end, so later input changes must not show
        @(posedge clk);
        t_data <= ~old_t;
        mst.start();
        put(8'h86, 1'b1);
        put(8'h30, 1'b1);
        mst.start();
        put(8'h87, 1'b1);
        get(1'b0, old_t[7:0]);
        get(1'b0, old_t[15:8]);
        get(1'b1, 8'h01);
        mst.stop();
        $display("test readout done");
    endtask : test_readout
    task automatic test_stay_active();
        mst.start();
        put(8'h86, 1'b1);
        put(8'h10, 1'b1);
        put(8'h00, 1'b1);
        put(8'h55, 1'b0);
        mst.stop();
        mst.start();
        put(8'h86, 1'b1);
        put(8'h21, 1'b1);
        // continuous T and H, then a stop request ends the repeat cycle
        put(8'h03, 1'b1);
        put(8'h03, 1'b1);
        put(8'h03, 1'b1);
        mst.stop();
        mst.start();
        put(8'h86, 1'b1);
        put(8'h24, 1'b1);
        mst.start();
        put(8'h87, 1'b1);
        get(1'b0, 8'h80);
        get(1'b1, 8'h00);
        mst.stop();
        `SHS_CHECK(pwr, PWR_ACTIVE)
        $display("test stay active done");
    endtask : test_stay_active
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // ************************************
    // sequence
    // ************************************
    initial begin
        rst_n = 1'b0;
        t_data = 16'hA5C3;
        h_data = 16'h3C5A;
        fails = 0;
        n_checks = 0;
        act_cnt = 0;
        repeat (12) @(posedge clk);
        test_reset();
        test_foreign();
        test_single();
        test_readout();
        test_stay_active();
        complete_run();
    end
    initial begin
        repeat (150000) @(posedge clk);
        fails++;
        $display("watchdog expired");
        complete_run();
    end
endmodule : sensor_i2c_slave_power_fsm_bench

// File: sim/shs_i2c_master.sv
`timescale 1ns/100ps
module shs_i2c_master #(
    parameter int Q = 125 // quarter bit period, 400 kbit/s at 200 MHz
) (
    input wire logic i_clk, // clock
    input wire logic i_sda, // resolved data line
    output logic o_scl, // bus clock
    output logic o_sda_low // high pulls data low
);
    import shs_pkg::*;
    // ************************************
    // bus master tasks
    // ************************************
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    task automatic bit_io(input logic b, output logic r);
        o_sda_low <= !b;
        tick(Q);
        o_scl <= 1'b1;
        tick(Q);
        r = i_sda;
        tick(Q);
        o_scl <= 1'b0;
        tick(Q);
    endtask : bit_io
    task automatic start();
        o_sda_low <= 1'b0;
        tick(Q);
        o_scl <= 1'b1;
        tick(Q);
        o_sda_low <= 1'b1;
        tick(Q);
        o_scl <= 1'b0;
        tick(Q);
    endtask : start
    task automatic stop();
        o_sda_low <= 1'b1;
        tick(Q);
        o_scl <= 1'b1;
        tick(Q);
        o_sda_low <= 1'b0;
        tick(2 * Q);
    endtask : stop
    task automatic wr_byte(input shs_byte_t d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        // released so the pull-up shows a refusal
        bit_io(1'b1, r);
        ack = !r;
    endtask : wr_byte
    task automatic rd_byte(input logic last, output shs_byte_t d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask : rd_byte
endmodule : shs_i2c_master
